// ### design/sidr_regs.sv
// Top: identification and block-read length register bank
`timescale 1ns/100ps

// The bank answers reads at offsets 5 to 7 and takes writes from the
// byte engine one strobe at a time. Offsets 5 and 6 are wired from
// parameters, so a write can never disturb them; the engine still
// receives an acknowledge, which keeps the host from seeing a refusal.
// Offset 7 keeps only its five length bits; the three upper bits read
// as zero whatever is written. The block read walker starts from any
// offset the host names and reports the last byte once the count of
// acknowledged bytes meets the stored length, so a length of L gives
// L plus one bytes. A start always wins over an acknowledge in the
// same cycle, which lets a host abandon a read and begin another.

// Overview of operation
// - Offset 5 holds revision and maker nibbles
// - Offset 6 holds read-only part code
// - Offset 7 bits 4:0 read length, rest reserved
// - Read length sets block read byte count
// - Read length resets to 8, nine bytes
// - Default block read returns offsets 0..8 ascending
module sidr_regs #(
  parameter logic [3:0] REV_CODE   = 4'h1,   // Arbitrary value
  parameter logic [3:0] MAKER_CODE = 4'h5,   // Arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h3C,  // Arbitrary value
  parameter int         LEN_W      = 5
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // Register write from the byte engine
  input  wire sidr_pkg::sidr_wr_type wr,
  output logic                      wr_ack,
  // Register read port (offset 5..7)
  input  wire logic [2:0]           rd_addr,
  output logic [7:0]                rd_data,
  // Block read sequencing
  input  wire logic                 blk_start,
  input  wire logic [7:0]           blk_start_ofs,
  input  wire logic                 blk_ack,
  output logic [7:0]                blk_ofs,
  output logic                      blk_last,
  output logic [LEN_W-1:0]          read_length
);

  // Stored field and its next value
  logic [LEN_W-1:0] len_q;     // Read length field
  logic [LEN_W-1:0] len_d;     // Next read length
  logic             len_hit;   // Write aimed at the length byte
  // Bytes as the host reads them
  logic [7:0]       byte5;     // Revision and maker byte
  logic [7:0]       byte6;     // Part code byte
  logic [7:0]       byte7;     // Length byte as read
  // Read decode
  logic             sel_rev;   // Read aimed at offset 5
  logic             sel_part;  // Read aimed at offset 6
  logic             sel_len;   // Read aimed at offset 7
  logic [7:0]       rd_d;      // Next read data
  logic             ack_q;     // Write acknowledge

  // Read-only identification bytes; no storage, so writes cannot reach
  assign byte5 = {REV_CODE, MAKER_CODE};
  assign byte6 = PART_CODE;
  // Reserved bits are tied low rather than stored
  assign byte7 = {3'h0, len_q};

  // Only the length field takes writes; reserved bits dropped
  assign len_hit = wr.wr_en && (wr.addr == sidr_pkg::OFS_READ_LEN);
  assign len_d   = len_hit ? wr.wdata[sidr_pkg::LEN_MSB:sidr_pkg::LEN_LSB]
                           : len_q;

  // Offset decode, one wire per register
  assign sel_rev  = (rd_addr == sidr_pkg::OFS_REV_VENDOR);
  assign sel_part = (rd_addr == sidr_pkg::OFS_PART_CODE);
  assign sel_len  = (rd_addr == sidr_pkg::OFS_READ_LEN);

  // Read data selection; unmapped offsets read as zero
  assign rd_d = sel_rev  ? byte5 :
                sel_part ? byte6 :
                sel_len  ? byte7 : 8'h00;

  // Length register, ack and read data
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      len_q   <= sidr_pkg::READ_LEN_RESET;
      ack_q   <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      len_q   <= len_d;
      ack_q   <= wr.wr_en;
      rd_data <= rd_d;
    end
  end

  // Acknowledge goes out for every write, mapped or not
  assign wr_ack      = ack_q;
  // Length field also drives the transmit side of the byte engine
  assign read_length = len_q;

  // Block read walker; it sees the stored length directly, so a
  // length written during a read takes effect on that same read
  // (hosts should change it only between reads)
  sidr_stream #(.LEN_W(LEN_W)) u_stream (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .start     (blk_start),
    .start_ofs (blk_start_ofs),
    .advance   (blk_ack),
    .length    (len_q),
    .cur_ofs   (blk_ofs),
    .last_byte (blk_last)
  );

  // Assertion helpers: bytes acknowledged since the last block start,
  // counted apart from the walker so the last flag is judged on its own
  logic [7:0] chk_cnt_q;  // Shadow byte count
  logic [7:0] chk_cnt_d;  // Next shadow count
  logic       chk_end;    // Shadow says the last byte is up
  logic       rd_other;   // Read aimed outside the bank

  // Shadow count follows the same start and acknowledge strobes
  assign chk_cnt_d = blk_start ? 8'h00 :
                     (blk_ack ? chk_cnt_q + 8'h01 : chk_cnt_q);
  assign chk_end   = (chk_cnt_q == {3'h0, len_q});
  assign rd_other  = !sel_rev && !sel_part && !sel_len;

  // Shadow count register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chk_cnt_q <= 8'h00;
    end else begin
      chk_cnt_q <= chk_cnt_d;
    end
  end

  // Named steps of the transfers
  // Start strobe for one cycle, then dropped
  sequence blk_open_s;
    blk_start ##1 !blk_start;
  endsequence
  // Host acknowledge not overridden by a new start
  sequence blk_step_s;
    blk_ack && !blk_start;
  endsequence
  // One-cycle write strobe
  sequence wr_pulse_s;
    wr.wr_en ##1 !wr.wr_en;
  endsequence
  // Write aimed at an identification byte or an unmapped offset
  sequence id_write_s;
    wr.wr_en && (wr.addr != sidr_pkg::OFS_READ_LEN);
  endsequence

  // Assertions

  // Reset and storage
  // Length comes back to its default after every reset
  len_reset_a: assert property (@(posedge ref_clk)
    rst |=> len_q == 5'h08)
    else $error("length not 8 after reset");
  // Identification bytes never move, whatever is written
  id_const_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr.wr_en |=> byte5 == {REV_CODE, MAKER_CODE} &&
                 byte6 == PART_CODE)
    else $error("id byte changed");
  // A length write lands on the next edge
  len_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    len_hit |=> len_q == $past(wr.wdata[4:0]))
    else $error("length write lost");
  // Without a length write the field holds
  len_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    !len_hit |=> $stable(len_q))
    else $error("length changed without write");
  // Writes elsewhere leave the length alone
  id_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    id_write_s |=> $stable(len_q))
    else $error("length changed by id write");

  // Reads
  // Offset 5 reads revision over maker nibble
  rd_rev_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_addr == 3'h5 |=> rd_data == {REV_CODE, MAKER_CODE})
    else $error("offset 5 read wrong");
  // Offset 6 reads the part code
  rd_part_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_addr == 3'h6 |=> rd_data == PART_CODE)
    else $error("offset 6 read wrong");
  // Reserved bits of offset 7 read low
  rd_len_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_addr == 3'h7 |=> rd_data[7:5] == 3'h0)
    else $error("reserved bits set");
  // Offset 7 reads back the stored length
  rd_len_val_a: assert property (@(posedge ref_clk) disable iff (rst)
    sel_len |=> rd_data[4:0] == $past(len_q))
    else $error("length read back wrong");
  // Unmapped offsets read as zero
  rd_other_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_other |=> rd_data == 8'h00)
    else $error("unmapped offset read not zero");

  // Block read
  // Each acknowledge without a start in the same cycle moves to the next offset up
  blk_step_a: assert property (@(posedge ref_clk) disable iff (rst)
    blk_step_s |=> blk_ofs == $past(blk_ofs) + 8'h01)
    else $error("offset not ascending");
  // First byte is not the last unless the length is zero
  blk_first_a: assert property (@(posedge ref_clk) disable iff (rst)
    blk_start |=> !blk_last || len_q == 5'h00)
    else $error("last flagged too early");
  // First byte comes from the requested start offset
  blk_open_a: assert property (@(posedge ref_clk) disable iff (rst)
    blk_open_s |-> blk_ofs == $past(blk_start_ofs))
    else $error("block read started at wrong offset");
  // Last flag exactly when the shadow count of acknowledged bytes equals the length
  blk_len_a: assert property (@(posedge ref_clk) disable iff (rst)
    blk_last == chk_end)
    else $error("last flag at wrong byte count");

  // Write handling
  // Every write is acknowledged
  ack_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr.wr_en |=> wr_ack)
    else $error("write not acknowledged");
  // Acknowledge stands one cycle per strobe
  wr_once_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_pulse_s |=> !wr_ack)
    else $error("acknowledge held too long");

endmodule : sidr_regs

// ### design/sidr_pkg.sv
// Package: offsets, field layouts, reset values and types for the ID block
package sidr_pkg;

  // Register byte offsets
  localparam logic [2:0] OFS_REV_VENDOR = 3'h5;  // Revision and maker code
  localparam logic [2:0] OFS_PART_CODE  = 3'h6;  // Part code byte
  localparam logic [2:0] OFS_READ_LEN   = 3'h7;  // Block read length

  // Field positions
  localparam int REV_MSB     = 7;  // Revision nibble top bit
  localparam int REV_LSB     = 4;  // Revision nibble bottom bit
  localparam int MAKER_MSB   = 3;  // Maker nibble top bit
  localparam int MAKER_LSB   = 0;  // Maker nibble bottom bit
  localparam int LEN_MSB     = 4;  // Read length top bit
  localparam int LEN_LSB     = 0;  // Read length bottom bit
  localparam int LEN_W       = 5;  // Read length width

  // Reset values
  localparam logic [4:0] READ_LEN_RESET = 5'h08;  // Nine bytes by default

  // Byte-lane access carried from the byte engine
  typedef struct packed {
    logic       wr_en;   // One-cycle write strobe
    logic [2:0] addr;    // Register offset
    logic [7:0] wdata;   // Write data
  } sidr_wr_type;

endpackage : sidr_pkg

// ### design/sidr_stream.sv
// Block read sequencer: walks register offsets for a block read
`timescale 1ns/100ps
module sidr_stream #(
  parameter int LEN_W = 5
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Control from the byte engine
  input  wire logic             start,
  input  wire logic [7:0]       start_ofs,
  input  wire logic             advance,
  input  wire logic [LEN_W-1:0] length,
  // Sequencer state
  output logic [7:0]            cur_ofs,
  output logic                  last_byte
);

  logic [7:0] ofs_q;    // Current register offset
  logic [7:0] cnt_q;    // Bytes already sent
  logic [7:0] cnt_d;    // Next count
  logic [7:0] ofs_d;    // Next offset

  // Next-state selection
  assign ofs_d = start ? start_ofs : (advance ? ofs_q + 8'h01 : ofs_q);
  assign cnt_d = start ? 8'h00 : (advance ? cnt_q + 8'h01 : cnt_q);

  // Last byte when count reaches the length setting (length+1 bytes)
  assign last_byte = (cnt_q == {{(8-LEN_W){1'b0}}, length});
  assign cur_ofs   = ofs_q;

  // Offset and count registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ofs_q <= 8'h00;
      cnt_q <= 8'h00;
    end else begin
      ofs_q <= ofs_d;
      cnt_q <= cnt_d;
    end
  end

endmodule : sidr_stream

// ### test/sidr_host_model.sv
// Host model: runs block reads and judges the returned offsets
`timescale 1ns/100ps
module sidr_host_model (
  // Clock and request from the bench
  input  wire logic       ref_clk,
  input  wire logic       go,
  input  wire logic [7:0] ofs,
  // Device side of the block read
  input  wire logic [7:0] blk_ofs,
  input  wire logic       blk_last,
  output logic            blk_start     = 1'b0,
  output logic [7:0]      blk_start_ofs = 8'h00,
  output logic            blk_ack       = 1'b0,
  // Result of the last block read
  output logic            busy          = 1'b0,
  output logic [7:0]      n             = 8'h00,
  output logic            ok            = 1'b1
);
  // Start pulse, then one ack per byte until the device flags the last
  always @(negedge ref_clk) begin
    blk_start <= 1'b0;
    blk_ack   <= 1'b0;
    if (go) begin
      blk_start     <= 1'b1;
      blk_start_ofs <= ofs;
      busy          <= 1'b1;
      n             <= 8'h00;
      ok            <= 1'b1;
    end else if (busy && !blk_start) begin
      // Each byte must be one offset above the one before
      if (blk_ofs !== blk_start_ofs + n) ok <= 1'b0;
      n <= n + 8'h01;
      // Stop acking once the length field says the last byte is out
      if (blk_last) busy <= 1'b0;
      else blk_ack <= 1'b1;
    end
  end
endmodule : sidr_host_model

// ### test/smbus_id_and_readback_length_regs_bench.sv
// Bench: ID reads, write filtering and block read lengths
`timescale 1ns/100ps
`define CHK(nm, ex, got) compares++; if ((got) !== (ex)) begin \
  num_errors++; $display("Error %s exp %h got %h", nm, ex, got); end
module smbus_id_and_readback_length_regs_bench;
  logic                  ref_clk = 1'b0;   // 25 MHz clock
  logic                  rst     = 1'b1;   // Sync reset
  sidr_pkg::sidr_wr_type wr      = '0;     // Write lane
  logic [2:0]            rd_addr = 3'h0;   // Read offset
  logic                  go      = 1'b0;   // Block read request
  logic [7:0]            ofs     = 8'h00;  // Block read start
  logic                  wr_ack, blk_start, blk_ack, blk_last, busy, ok;
  logic [7:0]            rd_data, blk_start_ofs, blk_ofs, n;
  logic [4:0]            read_length;
  int                    num_errors = 0;
  int                    compares   = 0;
  // Arbitrary ID values, distinct nibbles to catch swaps
  sidr_regs #(.REV_CODE(4'hA), .MAKER_CODE(4'h6), .PART_CODE(8'h9B)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .wr(wr), .wr_ack(wr_ack),
    .rd_addr(rd_addr), .rd_data(rd_data), .blk_start(blk_start),
    .blk_start_ofs(blk_start_ofs), .blk_ack(blk_ack), .blk_ofs(blk_ofs),
    .blk_last(blk_last), .read_length(read_length));
  sidr_host_model u_host (
    .ref_clk(ref_clk), .go(go), .ofs(ofs), .blk_ofs(blk_ofs),
    .blk_last(blk_last), .blk_start(blk_start),
    .blk_start_ofs(blk_start_ofs), .blk_ack(blk_ack), .busy(busy),
    .n(n), .ok(ok));
  // Clock generator
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // Read one offset and compare the registered data
  task rd_chk(input logic [2:0] a, input logic [7:0] ex);
    @(negedge ref_clk) rd_addr <= a;
    @(negedge ref_clk);
    `CHK("rd_data", ex, rd_data)
  endtask : rd_chk
  // Single write; the ack must follow whatever the offset
  task wr_do(input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk) wr <= {1'b1, a, d};
    @(negedge ref_clk) wr.wr_en <= 1'b0;
    `CHK("wr_ack", 1'b1, wr_ack)
  endtask : wr_do
  // Block read from offset o, expecting ex bytes in ascending order
  task blk_chk(input logic [7:0] o, input logic [7:0] ex);
    int i;
    @(negedge ref_clk) go <= 1'b1;
    ofs <= o;
    @(negedge ref_clk) go <= 1'b0;
    @(negedge ref_clk);
    for (i = 0; i < 40 && busy; i++) @(negedge ref_clk);
    `CHK("blk_count", ex, n)
    `CHK("blk_order", 1'b1, ok)
  endtask : blk_chk
  // Values after reset, then a default nine-byte block read
  task t_reset;
    rd_chk(sidr_pkg::OFS_REV_VENDOR, 8'hA6);
    rd_chk(sidr_pkg::OFS_PART_CODE, 8'h9B);
    rd_chk(sidr_pkg::OFS_READ_LEN, 8'h08);
    `CHK("read_length", 5'h08, read_length)
    blk_chk(8'h00, 8'h09);
  endtask : t_reset
  // ID writes ignored, reserved bits dropped, new length obeyed
  task t_writes;
    wr_do(3'h5, 8'hFF);
    wr_do(3'h6, 8'h00);
    rd_chk(3'h5, 8'hA6);
    rd_chk(3'h6, 8'h9B);
    wr_do(3'h7, 8'hE3);
    `CHK("read_length", 5'h03, read_length)
    rd_chk(3'h7, 8'h03);
    rd_chk(3'h2, 8'h00);
    blk_chk(8'h02, 8'h04);
  endtask : t_writes
  // Mid-run reset puts the length back to its default
  task t_rerst;
    @(negedge ref_clk) rst <= 1'b1;
    repeat (2) @(negedge ref_clk);
    rst <= 1'b0;
    `CHK("read_length", 5'h08, read_length)
    rd_chk(sidr_pkg::OFS_READ_LEN, 8'h08);
    blk_chk(8'h00, 8'h09);
  endtask : t_rerst
  // Counts, verdict and end of run
  task stop_test;
    $display("Compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // Main sequence
  initial begin
    repeat (20) @(negedge ref_clk);
    rst <= 1'b0;
    t_reset;
    t_writes;
    t_rerst;
    stop_test;
  end
  // Watchdog at 2500 cycles, far beyond the fewer than 100 cycles the tests need
  initial begin
    #100000;
    num_errors++;
    stop_test;
  end
endmodule : smbus_id_and_readback_length_regs_bench
